// File: design/umsp_regs.svh
`ifndef UMSP_REGS_SVH
`define UMSP_REGS_SVH
// APB byte offsets
`define UMSP_MCR_OFS 12'h000
`define UMSP_FCR_OFS 12'h004
`define UMSP_EFR_OFS 12'h008
`define UMSP_EMS_OFS 12'h00C
`define UMSP_IER_OFS 12'h010
`define UMSP_MSR_OFS 12'h014
`define UMSP_TXD_OFS 12'h018
`define UMSP_RXD_OFS 12'h01C
`define UMSP_DIV_OFS 12'h020
`define UMSP_STS_OFS 12'h024
// Modem control bits
`define UMSP_MCR_DTR 0
`define UMSP_MCR_RTS 1
`define UMSP_MCR_OUT2 3
`define UMSP_MCR_IR 6
// Feature control bits
`define UMSP_FCR_RXINV 2
`define UMSP_FCR_DIR 3
// Enhanced feature bits
`define UMSP_EFR_ARTS 6
`define UMSP_EFR_ACTS 7
// Extended mode select: direction polarity
`define UMSP_EMS_DPOL 3
// Interrupt enable: CTS change
`define UMSP_IER_CTS 7
// Modem status bits
`define UMSP_MSR_DCTS 0
`define UMSP_MSR_CTS 4
`define UMSP_MSR_DSR 5
`define UMSP_MSR_RI 6
`define UMSP_MSR_CD 7
// Divisor reset value and fixed constants
`define UMSP_DIV_RST 16'h0036
`define UMSP_OVS 4'hF
`define UMSP_OVS_HALF 4'h7
`define UMSP_IR_PULSE 4'h5
`define UMSP_FIFO_HI 5'h0E
`define UMSP_FIFO_LO 5'h08
`endif

// File: design/umsp_pkg.sv
package umsp_pkg;
  // APB request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } umsp_apb_req_t;
  // APB answer bundle
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } umsp_apb_rsp_t;
  typedef enum logic [1:0] {UMSP_IDLE, UMSP_START, UMSP_DATA, UMSP_STOP} umsp_ser_t;
endpackage : umsp_pkg

// File: design/umsp_fifo.sv
`timescale 1ns/1ns
module umsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Fill level
  output logic [AW:0] level_o
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  // Honest full and empty flags
  assign in_ready_o = (cnt_reg != (AW + 1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rd_reg];
  assign level_o = cnt_reg;
  // Storage
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data_i;
  end
  // Pointers wrap at DEPTH
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : umsp_fifo

// File: design/umsp_top.sv
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "umsp_regs.svh"
module umsp_top #(
  parameter int FIFO_DEPTH = 16,
  parameter logic [15:0] DIV_RST = `UMSP_DIV_RST
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire umsp_pkg::umsp_apb_req_t apb_req_i,
  output umsp_pkg::umsp_apb_rsp_t apb_rsp_o,
  // Serial pins, channel A
  output logic serial_out_a_o,
  input wire logic serial_in_a_i,
  // Modem pins, channel A
  output logic request_to_send_a_n_o,
  input wire logic clear_to_send_a_n_i,
  output logic terminal_ready_a_n_o,
  input wire logic set_ready_a_n_i,
  input wire logic carrier_detect_a_n_i,
  input wire logic ring_indicator_a_n_i,
  output logic output_port2_a_n_o,
  // Interrupt pin as level plus enable
  output logic irq_out_a_o,
  output logic irq_out_a_oe_o,
  // Channel B receive status
  input wire logic rx_b_avail_i,
  output logic rx_ready_b_n_o
);
  import umsp_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] modem_control_reg;
  logic [7:0] feature_control_reg;
  logic [7:0] enhanced_feature_reg;
  logic [7:0] extended_mode_select_reg;
  logic [7:0] interrupt_enable_reg;
  logic dcts_reg;
  logic [15:0] div_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // ----------------------------------------------------------------
  // Pin synchronisers (three stages, change taken when 2 and 3 agree)
  // ----------------------------------------------------------------
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] pin_reg;
  assign pin_raw = {ring_indicator_a_n_i, carrier_detect_a_n_i, set_ready_a_n_i,
    clear_to_send_a_n_i, serial_in_a_i};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      // Idle-high reset avoids a false start after reset
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
        begin
          s1_reg[gi] <= 1'b1;
          s2_reg[gi] <= 1'b1;
          s3_reg[gi] <= 1'b1;
          pin_reg[gi] <= 1'b1;
        end
        else
        begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi])
            pin_reg[gi] <= s3_reg[gi];
        end
      end
    end
  endgenerate
  wire rx_pin = pin_reg[0];
  wire cts_n = pin_reg[1];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire apb_setup = apb_req_i.psel && !apb_req_i.penable;
  wire apb_acc = apb_req_i.psel && apb_req_i.penable && pready_reg;
  wire apb_wr = apb_acc && apb_req_i.pwrite;
  wire apb_rd = apb_acc && !apb_req_i.pwrite;
  wire [11:0] a = apb_req_i.paddr;
  wire hit_mcr = (a == `UMSP_MCR_OFS);
  wire hit_fcr = (a == `UMSP_FCR_OFS);
  wire hit_efr = (a == `UMSP_EFR_OFS);
  wire hit_ems = (a == `UMSP_EMS_OFS);
  wire hit_ier = (a == `UMSP_IER_OFS);
  wire hit_msr = (a == `UMSP_MSR_OFS);
  wire hit_txd = (a == `UMSP_TXD_OFS);
  wire hit_rxd = (a == `UMSP_RXD_OFS);
  wire hit_div = (a == `UMSP_DIV_OFS);
  wire hit_sts = (a == `UMSP_STS_OFS);
  wire hit_any = hit_mcr | hit_fcr | hit_efr | hit_ems | hit_ier | hit_msr | hit_txd
    | hit_rxd | hit_div | hit_sts;

  // ----------------------------------------------------------------
  // Modem status
  // ----------------------------------------------------------------
  logic cts_q_reg;
  wire cts_edge = (cts_q_reg != cts_n);
  wire [7:0] msr_val = {~pin_reg[3], ~pin_reg[4], ~pin_reg[2], ~cts_n, 3'h0, dcts_reg};
  // change flag, set wins over the read clear
  wire dcts_next = cts_edge ? 1'b1 : ((apb_rd && hit_msr) ? 1'b0 : dcts_reg);

  // ----------------------------------------------------------------
  // FIFOs, transmit and receive
  // ----------------------------------------------------------------
  logic tx_in_rdy;
  logic tx_out_vld;
  logic [7:0] tx_out_dat;
  logic tx_take;
  logic rx_in_vld;
  logic [7:0] rx_in_dat;
  logic rx_in_rdy;
  logic rx_out_vld;
  logic [7:0] rx_out_dat;
  logic [$clog2(FIFO_DEPTH):0] rx_lvl;
  wire tx_push = apb_wr && hit_txd && tx_in_rdy;
  wire rx_pop = apb_rd && hit_rxd;

  umsp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(tx_push),
    .in_ready_o(tx_in_rdy),
    .in_data_i(apb_req_i.pwdata[7:0]),
    .out_valid_o(tx_out_vld),
    .out_ready_i(tx_take),
    .out_data_o(tx_out_dat),
    .level_o()
  );

  umsp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(rx_in_vld),
    .in_ready_o(rx_in_rdy),
    .in_data_i(rx_in_dat),
    .out_valid_o(rx_out_vld),
    .out_ready_i(rx_pop),
    .out_data_o(rx_out_dat),
    .level_o(rx_lvl)
  );

  // ----------------------------------------------------------------
  // Oversample tick divider (16 ticks per bit)
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt_reg;
  wire tick = (tick_cnt_reg == 16'h0000);
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || tick)
      tick_cnt_reg <= div_reg;
    else
      tick_cnt_reg <= tick_cnt_reg - 16'h0001;
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  umsp_ser_t tx_st_reg;
  logic [3:0] tx_ph_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_sh_reg;
  wire ir_mode = modem_control_reg[`UMSP_MCR_IR];
  // automatic flow control holds off new characters while CTS is high
  wire cts_block = enhanced_feature_reg[`UMSP_EFR_ACTS] && cts_n;
  assign tx_take = (tx_st_reg == UMSP_IDLE) && tx_out_vld && !cts_block && tick;
  wire tx_bit_end = tick && (tx_ph_reg == `UMSP_OVS);
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      tx_st_reg <= UMSP_IDLE;
      tx_ph_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_sh_reg <= 8'h00;
    end
    else
    begin
      if (tick && tx_st_reg != UMSP_IDLE)
        tx_ph_reg <= tx_ph_reg + 4'h1;
      unique case (tx_st_reg)
        UMSP_IDLE:
          if (tx_take)
          begin
            tx_sh_reg <= tx_out_dat;
            tx_ph_reg <= 4'h0;
            tx_st_reg <= UMSP_START;
          end
        UMSP_START:
          if (tx_bit_end)
            tx_st_reg <= UMSP_DATA;
        UMSP_DATA:
          if (tx_bit_end)
          begin
            tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
            tx_bit_reg <= tx_bit_reg + 3'h1;
            if (tx_bit_reg == 3'h7)
              tx_st_reg <= UMSP_STOP;
          end
        UMSP_STOP:
          if (tx_bit_end)
            tx_st_reg <= UMSP_IDLE;
      endcase
    end
  end
  // Raw line level, high when idle
  logic tx_lvl;
  always_comb
  begin
    unique case (tx_st_reg)
      UMSP_START: tx_lvl = 1'b0;
      UMSP_DATA: tx_lvl = tx_sh_reg[0];
      default: tx_lvl = 1'b1;
    endcase
  end
  // infrared: a short high pulse for each zero bit, else low
  wire ir_tx = !tx_lvl && (tx_ph_reg < `UMSP_IR_PULSE);
  // standard mode passes the line level, idle high
  wire tx_pin_next = ir_mode ? ir_tx : tx_lvl;
  wire tx_busy = (tx_st_reg != UMSP_IDLE) || tx_out_vld;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  // optional inversion ahead of the infrared decoder
  wire ir_in = rx_pin ^ feature_control_reg[`UMSP_FCR_RXINV];
  logic ir_hold_reg;
  // decoder stretches a high pulse into one low bit time
  wire rx_line = ir_mode ? !(ir_in || ir_hold_reg) : rx_pin;
  umsp_ser_t rx_st_reg;
  logic [3:0] rx_ph_reg;
  logic [3:0] ir_cnt_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_sh_reg;
  logic rx_vld_reg;
  assign rx_in_vld = rx_vld_reg;
  assign rx_in_dat = rx_sh_reg;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ir_hold_reg <= 1'b0;
      ir_cnt_reg <= 4'h0;
    end
    else if (ir_in)
    begin
      ir_hold_reg <= 1'b1;
      ir_cnt_reg <= 4'h0;
    end
    else if (tick && ir_hold_reg)
    begin
      ir_cnt_reg <= ir_cnt_reg + 4'h1;
      if (ir_cnt_reg == `UMSP_OVS)
        ir_hold_reg <= 1'b0;
    end
  end
  // Sample mid-bit; a full FIFO drops the byte
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rx_st_reg <= UMSP_IDLE;
      rx_ph_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      rx_vld_reg <= 1'b0;
    end
    else
    begin
      rx_vld_reg <= 1'b0;
      if (tick)
      begin
        rx_ph_reg <= rx_ph_reg + 4'h1;
        unique case (rx_st_reg)
          UMSP_IDLE:
          begin
            rx_ph_reg <= 4'h0;
            if (!rx_line)
              rx_st_reg <= UMSP_START;
          end
          UMSP_START:
            if (rx_ph_reg == `UMSP_OVS_HALF)
            begin
              rx_ph_reg <= 4'h0;
              rx_st_reg <= rx_line ? UMSP_IDLE : UMSP_DATA;
            end
          UMSP_DATA:
            if (rx_ph_reg == `UMSP_OVS)
            begin
              rx_sh_reg <= {rx_line, rx_sh_reg[7:1]};
              rx_bit_reg <= rx_bit_reg + 3'h1;
              if (rx_bit_reg == 3'h7)
                rx_st_reg <= UMSP_STOP;
            end
          UMSP_STOP:
            if (rx_ph_reg == `UMSP_OVS)
            begin
              rx_vld_reg <= rx_line && rx_in_rdy;
              rx_st_reg <= UMSP_IDLE;
            end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Modem output selection
  // ----------------------------------------------------------------
  logic arts_hold_reg;
  wire [4:0] rx_lvl5 = 5'(rx_lvl);
  // hysteresis on the receive FIFO level for automatic RTS
  wire arts_next = (rx_lvl5 >= `UMSP_FIFO_HI) ? 1'b1 :
    ((rx_lvl5 <= `UMSP_FIFO_LO) ? 1'b0 : arts_hold_reg);
  wire dir_pol = extended_mode_select_reg[`UMSP_EMS_DPOL];
  wire rts_sw = modem_control_reg[`UMSP_MCR_RTS];
  // direction mode: active while sending, polarity selectable
  wire rts_dir_n = tx_busy ^ dir_pol;
  // software level unless an automatic function owns it
  wire rts_n_next = feature_control_reg[`UMSP_FCR_DIR] ? rts_dir_n :
    (enhanced_feature_reg[`UMSP_EFR_ARTS] ? (!rts_sw || arts_hold_reg) : !rts_sw);
  // terminal ready follows its bit inverted
  wire dtr_n_next = !modem_control_reg[`UMSP_MCR_DTR];
  wire out2 = modem_control_reg[`UMSP_MCR_OUT2];
  // Interrupt source: a CTS change when enabled, or receive data ready
  wire irq_src = (interrupt_enable_reg[`UMSP_IER_CTS] && dcts_reg) || rx_out_vld;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [31:0] rd_mux =
    hit_mcr ? {24'h0, modem_control_reg} :
    hit_fcr ? {24'h0, feature_control_reg} :
    hit_efr ? {24'h0, enhanced_feature_reg} :
    hit_ems ? {24'h0, extended_mode_select_reg} :
    hit_ier ? {24'h0, interrupt_enable_reg} :
    hit_msr ? {24'h0, msr_val} :
    hit_rxd ? {24'h0, rx_out_dat} :
    hit_div ? {16'h0, div_reg} :
    hit_sts ? {29'h0, tx_busy, !tx_in_rdy, rx_out_vld} : 32'h0;

  // ----------------------------------------------------------------
  // Register writes and bus answer (no wait state)
  // ----------------------------------------------------------------
  // Bus answer straight from its registers
  assign apb_rsp_o = '{pready: pready_reg, pslverr: pslverr_reg, prdata: prdata_reg};
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      modem_control_reg <= 8'h00;
      feature_control_reg <= 8'h00;
      enhanced_feature_reg <= 8'h00;
      extended_mode_select_reg <= 8'h00;
      interrupt_enable_reg <= 8'h00;
      div_reg <= DIV_RST;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end
    else
    begin
      pready_reg <= apb_setup;
      pslverr_reg <= apb_setup && !hit_any;
      if (apb_setup)
        prdata_reg <= apb_req_i.pwrite ? 32'h0 : rd_mux;
      if (apb_wr && hit_mcr)
        modem_control_reg <= apb_req_i.pwdata[7:0];
      if (apb_wr && hit_fcr)
        feature_control_reg <= apb_req_i.pwdata[7:0];
      if (apb_wr && hit_efr)
        enhanced_feature_reg <= apb_req_i.pwdata[7:0];
      if (apb_wr && hit_ems)
        extended_mode_select_reg <= apb_req_i.pwdata[7:0];
      if (apb_wr && hit_ier)
        interrupt_enable_reg <= apb_req_i.pwdata[7:0];
      if (apb_wr && hit_div)
        div_reg <= apb_req_i.pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      // Every modem output idles inactive (high) in reset
      serial_out_a_o <= 1'b1;
      request_to_send_a_n_o <= 1'b1;
      terminal_ready_a_n_o <= 1'b1;
      output_port2_a_n_o <= 1'b1;
      irq_out_a_o <= 1'b0;
      irq_out_a_oe_o <= 1'b0;
      rx_ready_b_n_o <= 1'b1;
      dcts_reg <= 1'b0;
      cts_q_reg <= 1'b1;
      arts_hold_reg <= 1'b0;
    end
    else
    begin
      serial_out_a_o <= tx_pin_next;
      request_to_send_a_n_o <= rts_n_next;
      terminal_ready_a_n_o <= dtr_n_next;
      // one bit drives both the interrupt enable and port 2
      output_port2_a_n_o <= !out2;
      irq_out_a_oe_o <= out2;
      irq_out_a_o <= irq_src;
      // low while channel B reports data
      rx_ready_b_n_o <= !rx_b_avail_i;
      dcts_reg <= dcts_next;
      cts_q_reg <= cts_n;
      arts_hold_reg <= arts_next;
    end
  end
endmodule : umsp_top

// File: verification/umsp_monitor.sv
`timescale 1ns/1ns
`include "umsp_regs.svh"
module umsp_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register bus
  input wire umsp_pkg::umsp_apb_req_t apb_req_i,
  input wire umsp_pkg::umsp_apb_rsp_t apb_rsp_o,
  // Pins
  input wire logic serial_out_a_o,
  input wire logic request_to_send_a_n_o,
  input wire logic terminal_ready_a_n_o,
  input wire logic output_port2_a_n_o,
  input wire logic irq_out_a_oe_o,
  input wire logic rx_b_avail_i,
  input wire logic rx_ready_b_n_o
);
  import umsp_pkg::*;
  logic [7:0] mcr_reg;
  logic wr_mcr;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ------
  // Shadow of the modem control word
  // ------
  assign wr_mcr = apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready
    && apb_req_i.pwrite && apb_req_i.paddr == `UMSP_MCR_OFS;
  // Tracks writes so pin levels can be tied to the written bits
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      mcr_reg <= 8'h00;
    else if (wr_mcr)
      mcr_reg <= apb_req_i.pwdata[7:0];
  end
  // All pins but the interrupt level idle right after any reset
  reset_idle_a: assert property (
    $fell(sys_rst_i) |-> serial_out_a_o && request_to_send_a_n_o && terminal_ready_a_n_o
      && output_port2_a_n_o && !irq_out_a_oe_o && rx_ready_b_n_o)
    else $error("pins not idle after reset");
  // Port 2 and interrupt enable share one bit
  op2_irq_link_a: assert property (
    output_port2_a_n_o == !irq_out_a_oe_o)
    else $error("port 2 and interrupt enable disagree");
  rx_ready_b_a: assert property (
    !$past(sys_rst_i) |-> rx_ready_b_n_o == !$past(rx_b_avail_i))
    else $error("channel B ready does not follow its buffer");
  mcr_pins_a: assert property (
    wr_mcr |-> ##2 terminal_ready_a_n_o == !mcr_reg[`UMSP_MCR_DTR]
      && output_port2_a_n_o == !mcr_reg[`UMSP_MCR_OUT2])
    else $error("modem outputs do not follow control bits");
  // Bus answer timing
  ready_next_a: assert property (
    apb_req_i.psel && !apb_req_i.penable |=> apb_rsp_o.pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (
    apb_rsp_o.pready |=> !apb_rsp_o.pready)
    else $error("ready longer than one cycle");
  ready_sel_a: assert property (
    apb_rsp_o.pready |-> apb_req_i.psel && apb_req_i.penable)
    else $error("ready outside an access");
  err_data_a: assert property (
    apb_rsp_o.pslverr |-> apb_rsp_o.pready && apb_rsp_o.prdata == 32'h0)
    else $error("error answer malformed");
endmodule : umsp_monitor

// File: verification/umsp_line_model.sv
`timescale 1ns/1ns
module umsp_line_model (
  // Line side of the channel
  input wire logic tx_i,
  output logic rx_o,
  output logic cts_n_o,
  // Bench controls
  input wire logic loop_i,
  input wire logic ir_i,
  input wire logic inv_i,
  input wire logic hold_i
);
  // ------
  // Transceiver echo
  // ------
  // standard idle high
  assign rx_o = loop_i ? (tx_i ^ inv_i) : (ir_i ? inv_i : 1'b1);
  // Holding off lets the bench stall the sender
  assign cts_n_o = hold_i;
endmodule : umsp_line_model

// File: verification/test_uart_modem_serial_pins.sv
`timescale 1ns/1ns
`include "umsp_regs.svh"
module test_uart_modem_serial_pins;
  import umsp_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  umsp_apb_req_t req = '0;
  umsp_apb_rsp_t rsp;
  logic tx, rx, rts_n, cts_n, dtr_n, op2_n, irq, oe, rdyb_n, err;
  logic dsr_n = 1'b1, cd_n = 1'b1, ri_n = 1'b1, availb = 1'b0;
  logic loop = 1'b1, ir = 1'b0, inv = 1'b0, hold = 1'b0;
  logic [31:0] q;
  logic [7:0] b;
  logic [7:0] sent [$];
  int n_fail = 0, n_checks = 0;
  // ------
  // Clock, design and line
  // ------
  always #5 clk_i = ~clk_i;
  // Channel B buffer state wanders at random
  always @(posedge clk_i) availb <= 1'($urandom);
  umsp_top #(.FIFO_DEPTH(16)) uut (.clk_i, .sys_rst_i, .apb_req_i(req), .apb_rsp_o(rsp),
    .serial_out_a_o(tx), .serial_in_a_i(rx), .request_to_send_a_n_o(rts_n),
    .clear_to_send_a_n_i(cts_n), .terminal_ready_a_n_o(dtr_n), .set_ready_a_n_i(dsr_n),
    .carrier_detect_a_n_i(cd_n), .ring_indicator_a_n_i(ri_n), .output_port2_a_n_o(op2_n),
    .irq_out_a_o(irq), .irq_out_a_oe_o(oe), .rx_b_avail_i(availb), .rx_ready_b_n_o(rdyb_n));
  umsp_line_model line (.tx_i(tx), .rx_o(rx), .cts_n_o(cts_n), .loop_i(loop), .ir_i(ir),
    .inv_i(inv), .hold_i(hold));
  // ------
  // Bench tasks
  // ------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic bail(input string what);
    n_fail++;
    $display("unexpected %s: expected done seen timeout", what);
    close_out();
  endtask : bail
  // One bus transfer; request held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 40);
    if (rsp.pready !== 1'b1)
      bail("bus ready");
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic wait_st(input int i, input logic v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `UMSP_STS_OFS, 32'h0);
      n++;
    end
    while (q[i] !== v && n < 300);
    if (q[i] !== v)
      bail("status wait");
  endtask : wait_st
  // Send a random byte and take it back through the line echo
  task automatic echo(input string what);
    b = 8'($urandom);
    wr(`UMSP_TXD_OFS, b);
    wait_st(0, 1'b1);
    apb(1'b0, `UMSP_RXD_OFS, 32'h0);
    check(what, q[7:0], b);
  endtask : echo
  // A mode switch can leave one stray byte behind
  task automatic settle();
    repeat (200) @(posedge clk_i);
    apb(1'b0, `UMSP_STS_OFS, 32'h0);
    if (q[0] === 1'b1)
      apb(1'b0, `UMSP_RXD_OFS, 32'h0);
  endtask : settle
  task automatic idle_pins();
    check("txd", tx, 1'h1);
    check("rts", rts_n, 1'h1);
    check("dtr", dtr_n, 1'h1);
    check("op2", op2_n, 1'h1);
    check("irq oe", oe, 1'h0);
  endtask : idle_pins
  // ------
  // Main sequence
  // ------
  initial
  begin
    void'($urandom(22623));
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    idle_pins();
    apb(1'b0, `UMSP_DIV_OFS, 32'h0);
    check("divisor", q, {16'h0, `UMSP_DIV_RST});
    apb(1'b1, `UMSP_DIV_OFS, 32'h0);
    $display("test reset done");
    // port 2 only ever follows the interrupt bit
    for (int i = 0; i < 8; i++)
    begin
      wr(`UMSP_MCR_OFS, {4'h0, i[2], 1'h0, i[1], i[0]});
      repeat (3) @(posedge clk_i);
      check("dtr", dtr_n, !i[0]);
      check("rts", rts_n, !i[1]);
      check("op2", op2_n, !i[2]);
      check("irq oe", oe, i[2]);
    end
    $display("test modem outputs done");
    wr(`UMSP_MCR_OFS, 8'h0B);
    for (int i = 0; i < 4; i++)
    begin
      {dsr_n, cd_n, ri_n} <= 3'($urandom);
      echo("std echo");
      check("txd idle", tx, 1'h1);
      apb(1'b0, `UMSP_MSR_OFS, 32'h0);
      check("status", q[7:4], {~cd_n, ~ri_n, ~dsr_n, ~cts_n});
    end
    // With the echo cut the far driver idles high and nothing arrives
    loop <= 1'b0;
    wr(`UMSP_TXD_OFS, 8'h5A);
    repeat (200) @(posedge clk_i);
    apb(1'b0, `UMSP_STS_OFS, 32'h0);
    check("quiet line", q[0], 1'h0);
    loop <= 1'b1;
    $display("test standard echo done");
    ir <= 1'b1;
    wr(`UMSP_MCR_OFS, 8'h48);
    settle();
    check("ir idle", tx, 1'h0);
    echo("ir echo");
    wr(`UMSP_FCR_OFS, 8'h04);
    inv <= 1'b1;
    settle();
    echo("ir inverted");
    $display("test infrared done");
    ir <= 1'b0;
    inv <= 1'b0;
    hold <= 1'b1;
    wr(`UMSP_FCR_OFS, 8'h00);
    wr(`UMSP_MCR_OFS, 8'h0B);
    settle();
    wr(`UMSP_EFR_OFS, 8'h80);
    for (int i = 0; i < 20; i++)
    begin
      b = 8'($urandom);
      sent.push_back(b);
      wr(`UMSP_TXD_OFS, b);
    end
    apb(1'b0, `UMSP_STS_OFS, 32'h0);
    check("tx full", q[1], 1'h1);
    check("held txd", tx, 1'h1);
    hold <= 1'b0;
    // Seventeen frames of 160 clocks at divisor zero
    repeat (17 * 160 + 200) @(posedge clk_i);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b0, `UMSP_RXD_OFS, 32'h0);
      check("rx fifo", q[7:0], sent[i]);
    end
    apb(1'b0, `UMSP_STS_OFS, 32'h0);
    check("rx empty", q[0], 1'h0);
    wr(`UMSP_IER_OFS, 8'h80);
    repeat (3) @(posedge clk_i);
    check("cts irq", irq, 1'h1);
    apb(1'b0, `UMSP_MSR_OFS, 32'h0);
    check("cts change", q[`UMSP_MSR_DCTS], 1'h1);
    apb(1'b0, `UMSP_MSR_OFS, 32'h0);
    check("cts change clear", q[`UMSP_MSR_DCTS], 1'h0);
    check("cts irq clear", irq, 1'h0);
    $display("test flow hold done");
    wr(`UMSP_EFR_OFS, 8'h00);
    wr(`UMSP_EMS_OFS, 8'h08);
    wr(`UMSP_FCR_OFS, 8'h08);
    wr(`UMSP_MCR_OFS, 8'h09);
    check("dir idle", rts_n, 1'h1);
    wr(`UMSP_TXD_OFS, 8'hA5);
    repeat (60) @(posedge clk_i);
    check("dir send", rts_n, 1'h0);
    repeat (200) @(posedge clk_i);
    check("dir done", rts_n, 1'h1);
    apb(1'b0, `UMSP_RXD_OFS, 32'h0);
    check("dir echo", q[7:0], 8'hA5);
    wr(`UMSP_EMS_OFS, 8'h00);
    repeat (4) @(posedge clk_i);
    check("dir low idle", rts_n, 1'h0);
    $display("test direction done");
    wr(`UMSP_FCR_OFS, 8'h00);
    wr(`UMSP_MCR_OFS, 8'h0A);
    wr(`UMSP_EFR_OFS, 8'h40);
    for (int i = 0; i < 14; i++)
      wr(`UMSP_TXD_OFS, 8'($urandom));
    repeat (14 * 160 + 100) @(posedge clk_i);
    check("auto rts hi", rts_n, 1'h1);
    check("irq level", irq, 1'h1);
    for (int i = 0; i < 6; i++)
    begin
      repeat (4) @(posedge clk_i);
      check("auto rts hold", rts_n, 1'h1);
      apb(1'b0, `UMSP_RXD_OFS, 32'h0);
    end
    repeat (4) @(posedge clk_i);
    check("auto rts lo", rts_n, 1'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    check("slverr", err, 1'h1);
    check("err data", q, 32'h0);
    $display("test auto rts done");
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    idle_pins();
    $display("test second reset done");
    close_out();
  end
endmodule : test_uart_modem_serial_pins
bind umsp_top umsp_monitor mon (.clk_i, .sys_rst_i, .apb_req_i, .apb_rsp_o, .serial_out_a_o,
  .request_to_send_a_n_o, .terminal_ready_a_n_o, .output_port2_a_n_o, .irq_out_a_oe_o,
  .rx_b_avail_i, .rx_ready_b_n_o);
